// *** rtl/ssh_pkg.sv ***
// shared constants and types for the status and sense handler ends
package ssh_pkg;
  // message lengths in bytes
  localparam logic [2:0] STAT_BYTES  = 3'h2;
  localparam logic [2:0] SENSE_BYTES = 3'h4;
  localparam logic [2:0] CMD_BYTES   = 3'h6;

  // command block fields
  localparam logic [2:0] CLASS_BASIC  = 3'h0;
  localparam logic [4:0] OP_REQ_SENSE = 5'h03;
  localparam int         CLASS_MSB    = 7;
  localparam int         CLASS_LSB    = 5;
  localparam int         OPCODE_MSB   = 4;

  // status byte, sense byte 0 and sense byte 1 fields
  localparam int STAT_ERR_BIT = 1;
  localparam int SENSE_AV_BIT = 7;
  localparam int SENSE_Z_BIT  = 6;
  localparam int TYPE_MSB     = 5;
  localparam int TYPE_LSB     = 4;
  localparam int CODE_MSB     = 3;
  localparam int ADDR_HI_MSB  = 4;

  // error types
  localparam logic [1:0] ET_DRIVE = 2'h0;
  localparam logic [1:0] ET_CTRL  = 2'h1;
  localparam logic [1:0] ET_CMD   = 2'h2;
  localparam logic [1:0] ET_MISC  = 2'h3;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_IRQ_STAT = 8'h00;
  localparam logic [7:0] REG_IRQ_MASK = 8'h04;
  localparam logic [7:0] REG_CTRL     = 8'h08;
  localparam logic [7:0] REG_RESULT   = 8'h0c;
  localparam logic [7:0] REG_SECTOR   = 8'h10;

  // interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_SENSE = 1;
  localparam int IRQ_BAD   = 2;
  localparam int IRQ_W     = 3;

  // control register: bit 0 auto sense, bits 3:1 unit number
  localparam logic [3:0] CTRL_RESET = 4'h1;
  localparam int         CTRL_AUTO  = 0;

  // link phase as {cd_n, io_n, msg_n}
  localparam logic [2:0] PH_STATUS = 3'h1;
  localparam logic [2:0] PH_MSG    = 3'h0;
  localparam logic [2:0] PH_CMD    = 3'h3;
  localparam logic [2:0] PH_DIN    = 3'h5;
  localparam logic [2:0] PH_FREE   = 3'h7;

  typedef enum logic [1:0] {I_WAIT, I_HOLD, I_FREE, I_SEL} ssh_ini_state_t;
  typedef enum logic [2:0] {T_IDLE, T_SELD, T_SETUP, T_REQ, T_REL, T_EXEC} ssh_tgt_state_t;
endpackage

// *** rtl/ssh_link_if.sv ***
// byte bus between the initiator and the disk controller
`timescale 1ns/1ps
interface ssh_link_if;
  logic       req_n;    // controller request, low active
  logic       ack_n;    // initiator acknowledge, low active
  logic       sel_n;    // initiator select, low active
  logic       bsy_n;    // controller busy, low active
  logic       cd_n;     // low: control phase
  logic       io_n;     // low: byte moves to initiator
  logic       msg_n;    // low: message byte
  logic [7:0] tgt_data; // controller to initiator byte
  logic [7:0] ini_data; // initiator to controller byte

  modport initiator (
    input  req_n, bsy_n, cd_n, io_n, msg_n, tgt_data,
    output ack_n, sel_n, ini_data
  );
  modport target (
    input  ack_n, sel_n, ini_data,
    output req_n, bsy_n, cd_n, io_n, msg_n, tgt_data
  );
endinterface

// *** rtl/ssh_target.sv ***
// disk controller end: command intake, sense return, status and message
`timescale 1ns/1ps
module ssh_target
  import ssh_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  ssh_link_if.target       link,
  input  wire logic        done_i,
  input  wire logic        err_i,
  input  wire logic [31:0] sense_i,
  output logic             busy_o,
  output logic [47:0]      cmd_block_o,
  output logic             cmd_valid_o
);
  ssh_tgt_state_t state;
  logic [9:0]     s1;
  logic [9:0]     s2;
  logic [2:0]     phase;
  logic [2:0]     idx;
  logic [7:0]     cmd [6];
  logic           ack_s;
  logic           sel_s;

  // two flops on every pin from the initiator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 10'h3_ff;
      s2 <= 10'h3_ff;
    end else begin
      s1 <= {link.ack_n, link.sel_n, link.ini_data};
      s2 <= s1;
    end
  end
  assign ack_s = s2[9];
  assign sel_s = s2[8];

  assign link.cd_n  = phase[2];
  assign link.io_n  = phase[1];
  assign link.msg_n = phase[0];
  assign busy_o     = ~link.bsy_n;
  assign cmd_block_o = {cmd[0], cmd[1], cmd[2], cmd[3], cmd[4], cmd[5]};

  // byte sequencer: every byte is a full req/ack interlock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= T_IDLE;
      phase         <= PH_FREE;
      idx           <= 3'h0;
      link.req_n    <= 1'b1;
      link.bsy_n    <= 1'b1;
      link.tgt_data <= 8'h00;
      cmd_valid_o   <= 1'b0;
      for (int i = 0; i < 6; i++) cmd[i] <= 8'h00;
    end else begin
      cmd_valid_o <= 1'b0;
      unique case (state)
        T_IDLE: begin
          if (!sel_s) begin
            link.bsy_n <= 1'b0;
            state      <= T_SELD;
          end else if (done_i) begin
            // don't-care status bits 5, 3, 2 echo the low sense byte as vendor noise;
            // the initiator must look at bit 1 alone
            link.bsy_n    <= 1'b0;
            phase         <= PH_STATUS;
            link.tgt_data <= (sense_i[7:0] & 8'h2c) | {6'h00, err_i, 1'b0};
            state         <= T_SETUP;
          end
        end
        T_SELD: if (sel_s) begin
          phase <= PH_CMD;
          idx   <= 3'h0;
          state <= T_SETUP;
        end
        // data stands a cycle before req falls
        T_SETUP: begin
          link.req_n <= 1'b0;
          state      <= T_REQ;
        end
        T_REQ: if (!ack_s) begin
          if (phase == PH_CMD) cmd[idx] <= s2[7:0];
          link.req_n <= 1'b1;
          state      <= T_REL;
        end
        T_REL: if (ack_s) begin
          state <= T_SETUP;
          unique case (phase)
            PH_CMD: begin
              if (idx == CMD_BYTES - 3'h1) begin
                idx <= 3'h0;
                if (cmd[0] == {CLASS_BASIC, OP_REQ_SENSE}) begin
                  phase         <= PH_DIN;
                  link.tgt_data <= sense_i[31:24] & ~(8'h01 << SENSE_Z_BIT);
                end else begin
                  cmd_valid_o <= 1'b1;
                  state       <= T_EXEC;
                end
              end else begin
                idx <= idx + 3'h1;
              end
            end
            PH_DIN: begin
              if (idx == SENSE_BYTES - 3'h1) begin
                phase         <= PH_STATUS;
                link.tgt_data <= 8'h00;
              end else begin
                idx           <= idx + 3'h1;
                link.tgt_data <= sense_i[8'(23 - 8 * idx) -: 8];
              end
            end
            PH_STATUS: begin
              phase         <= PH_MSG;
              link.tgt_data <= 8'h00;
            end
            default: begin
              // completion byte done: release the bus
              phase      <= PH_FREE;
              link.bsy_n <= 1'b1;
              state      <= T_IDLE;
            end
          endcase
        end
        T_EXEC: if (done_i) begin
          phase         <= PH_STATUS;
          link.tgt_data <= (sense_i[7:0] & 8'h2c) | {6'h00, err_i, 1'b0};
          state         <= T_SETUP;
        end
      endcase
    end
  end
endmodule

// *** rtl/ssh_initiator.sv ***
// initiator end: status intake, automatic sense request and sense decode
`timescale 1ns/1ps
module ssh_initiator
  import ssh_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  ssh_link_if.initiator    link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o
);
  ssh_ini_state_t state;
  logic [12:0]    s1;
  logic [12:0]    s2;
  logic           req_s;
  logic           bsy_s;
  logic [2:0]     phase_s;
  logic [7:0]     data_s;
  logic [2:0]     stat_cnt;
  logic [2:0]     cmd_idx;
  logic [2:0]     din_idx;
  logic [7:0]     stat_byte;
  logic [7:0]     sense [4];
  logic           in_sense;
  logic           last_msg;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [3:0]     ctrl;
  logic           ev_done;
  logic           ev_sense;
  logic           ev_bad;
  logic           res_av;
  logic [1:0]     res_type;
  logic [3:0]     res_code;
  logic           res_known;
  logic [20:0]    sector;
  logic           wr_stb;
  logic           bus_req;

  // byte of the sense request command block
  function automatic logic [7:0] cmd_byte(input logic [2:0] i, input logic [2:0] unit);
    unique case (i)
      3'h0:    cmd_byte = {CLASS_BASIC, OP_REQ_SENSE};
      3'h1:    cmd_byte = {unit, 5'h00};
      default: cmd_byte = 8'h00;
    endcase
  endfunction

  // is a type and code pair one of the accepted errors
  function automatic logic code_ok(input logic [1:0] t, input logic [3:0] c);
    unique case (t)
      ET_DRIVE: code_ok = (c <= 4'h4) || (c == 4'h6) || (c == 4'h8);
      ET_CTRL:  code_ok = (c <= 4'h5) || (c == 4'h9) || (c == 4'ha)
                          || (c == 4'hc) || (c == 4'hd);
      ET_CMD:   code_ok = (c <= 4'h5);
      default:  code_ok = (c <= 4'h2);
    endcase
  endfunction

  // two flops on every pin from the controller
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 13'h1f_00;
      s2 <= 13'h1f_00;
    end else begin
      s1 <= {link.req_n, link.bsy_n, link.cd_n, link.io_n, link.msg_n, link.tgt_data};
      s2 <= s1;
    end
  end
  assign req_s   = s2[12];
  assign bsy_s   = s2[11];
  assign phase_s = s2[10:8];
  assign data_s  = s2[7:0];

  // byte handler: ack each byte, release ack only once req is back high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= I_WAIT;
      link.ack_n    <= 1'b1;
      link.sel_n    <= 1'b1;
      link.ini_data <= 8'h00;
      stat_cnt      <= 3'h0;
      cmd_idx       <= 3'h0;
      din_idx       <= 3'h0;
      stat_byte     <= 8'h00;
      in_sense      <= 1'b0;
      last_msg      <= 1'b0;
      ev_done       <= 1'b0;
      ev_sense      <= 1'b0;
      for (int i = 0; i < 4; i++) sense[i] <= 8'h00;
    end else begin
      ev_done  <= 1'b0;
      ev_sense <= 1'b0;
      unique case (state)
        I_WAIT: if (!req_s && !bsy_s) begin
          last_msg   <= 1'b0;
          link.ack_n <= 1'b0;
          state      <= I_HOLD;
          unique case (phase_s)
            PH_STATUS: begin
              stat_byte <= data_s;
              stat_cnt  <= 3'h1;
            end
            PH_MSG: begin
              last_msg <= (stat_cnt == STAT_BYTES - 3'h1);
              stat_cnt <= 3'h0;
            end
            PH_CMD: begin
              link.ini_data <= cmd_byte(cmd_idx, ctrl[3:1]);
              if (cmd_idx != CMD_BYTES) cmd_idx <= cmd_idx + 3'h1;
            end
            PH_DIN: if (din_idx != SENSE_BYTES) begin
              sense[din_idx[1:0]] <= data_s;
              din_idx             <= din_idx + 3'h1;
            end
            default: ; // other phases are acknowledged and dropped
          endcase
        end
        I_HOLD: if (req_s) begin
          link.ack_n <= 1'b1;
          state      <= I_WAIT;
          // command finishes only on the second byte
          if (last_msg) begin
            if (in_sense) begin
              in_sense <= 1'b0;
              ev_sense <= (din_idx == SENSE_BYTES);
              ev_done  <= 1'b1;
            end else if (stat_byte[STAT_ERR_BIT] && ctrl[CTRL_AUTO]) begin
              state <= I_FREE;
            end else begin
              ev_done <= 1'b1;
            end
          end
        end
        // bus must be released before a new selection
        I_FREE: if (bsy_s) begin
          link.sel_n <= 1'b0;
          state      <= I_SEL;
        end
        I_SEL: if (!bsy_s) begin
          link.sel_n <= 1'b1;
          in_sense   <= 1'b1;
          cmd_idx    <= 3'h0;
          din_idx    <= 3'h0;
          state      <= I_WAIT;
        end
      endcase
    end
  end

  // decode latched when the sense block is complete
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_av    <= 1'b0;
      res_type  <= ET_DRIVE;
      res_code  <= 4'h0;
      res_known <= 1'b0;
      sector    <= 21'h00_0000;
      ev_bad    <= 1'b0;
    end else begin
      ev_bad <= 1'b0;
      if (ev_sense) begin
        res_av    <= sense[0][SENSE_AV_BIT];
        res_type  <= sense[0][TYPE_MSB:TYPE_LSB];
        res_code  <= sense[0][CODE_MSB:0];
        res_known <= code_ok(sense[0][TYPE_MSB:TYPE_LSB], sense[0][CODE_MSB:0]);
        ev_bad    <= ~code_ok(sense[0][TYPE_MSB:TYPE_LSB], sense[0][CODE_MSB:0]);
        // the address is only trusted with the valid flag set
        if (sense[0][SENSE_AV_BIT]) begin
          sector <= {sense[1][ADDR_HI_MSB:0], sense[2], sense[3]};
        end
      end
    end
  end

  // wishbone slave: one wait state, ack drops the cycle after
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb  = bus_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_IRQ_STAT: wb_dat_o <= {29'h0000_0000, irq_stat};
          REG_IRQ_MASK: wb_dat_o <= {29'h0000_0000, irq_mask};
          REG_CTRL:     wb_dat_o <= {28'h000_0000, ctrl};
          REG_RESULT:   wb_dat_o <= {14'h0000, (state != I_WAIT) || in_sense, res_known,
                                     res_code, res_type, res_av, stat_byte[STAT_ERR_BIT],
                                     stat_byte};
          REG_SECTOR:   wb_dat_o <= {11'h000, sector};
          default:      wb_dat_o <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  // control and mask registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= CTRL_RESET;
      irq_mask <= '0;
    end else if (wr_stb) begin
      if (wb_adr_i == REG_CTRL)     ctrl     <= wb_dat_i[3:0];
      if (wb_adr_i == REG_IRQ_MASK) irq_mask <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_stb && wb_adr_i == REG_IRQ_STAT) ?
                                wb_dat_i[IRQ_W-1:0] : '0))
                  | {ev_bad, ev_sense, ev_done};
    end
  end
  assign irq_o = |(irq_stat & irq_mask);
endmodule

// *** tb/ssh_link_assertions.sv ***
// protocol checks on the byte bus between the initiator and controller ends
`timescale 1ns/1ps
module ssh_link_assertions
  import ssh_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       req_n,
  input wire logic       ack_n,
  input wire logic       sel_n,
  input wire logic       bsy_n,
  input wire logic       cd_n,
  input wire logic       io_n,
  input wire logic       msg_n,
  input wire logic [7:0] tgt_data,
  input wire logic [7:0] ini_data
);
  logic [2:0] ph;
  logic [2:0] ph_q;
  logic       ack_q;
  logic [3:0] idx;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  assign ph = {cd_n, io_n, msg_n};

  // byte index within a phase; restarts when the phase lines move
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q  <= PH_FREE;
      ack_q <= 1'b1;
      idx   <= 4'h0;
    end else begin
      ph_q  <= ph;
      ack_q <= ack_n;
      if (ph != ph_q) idx <= 4'h0;
      else if (ack_n && !ack_q) idx <= idx + 4'h1;
    end
  end

  property p_ack_fall; $fell(req_n) && !bsy_n |-> ##3 $fell(ack_n); endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("ack late after req");
  property p_req_rise; $fell(ack_n) |-> ##3 $rose(req_n); endproperty
  a_req_rise: assert property (p_req_rise) else $error("req not withdrawn");
  property p_ack_rise; $rose(req_n) |-> ##3 $rose(ack_n); endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack not withdrawn");
  property p_hold; !req_n && !$fell(req_n) |-> $stable(tgt_data) && $stable(ph); endproperty
  a_hold: assert property (p_hold) else $error("byte moved during req");
  property p_stat_len; ph_q == PH_STATUS && ph != PH_STATUS |-> ph == PH_MSG && idx == 4'h1;
  endproperty
  a_stat_len: assert property (p_stat_len) else $error("status phase length");
  property p_msg_end; ph_q == PH_MSG && ph != PH_MSG |-> ph == PH_FREE && idx == 4'h1;
  endproperty
  a_msg_end: assert property (p_msg_end) else $error("bus not freed after message");
  property p_msg_byte; !msg_n && !req_n |-> tgt_data == 8'h00 && !cd_n && !io_n; endproperty
  a_msg_byte: assert property (p_msg_byte) else $error("message byte not zero");
  property p_sense_len; ph_q == PH_DIN && ph != PH_DIN |-> idx == {1'b0, SENSE_BYTES};
  endproperty
  a_sense_len: assert property (p_sense_len) else $error("sense length wrong");
  property p_cmd_len; ph_q == PH_CMD && ph != PH_CMD |-> idx == {1'b0, CMD_BYTES}; endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("command length wrong");
  property p_cmd_op;
    ph == PH_CMD && !ack_n && idx == 4'h0 |-> ini_data == {CLASS_BASIC, OP_REQ_SENSE};
  endproperty
  a_cmd_op: assert property (p_cmd_op) else $error("wrong command opcode");
  property p_sense_z; ph == PH_DIN && !req_n && idx == 4'h0 |-> !tgt_data[SENSE_Z_BIT];
  endproperty
  a_sense_z: assert property (p_sense_z) else $error("sense bit 6 set");

  c_sense: cover property (ph_q == PH_DIN && ph != PH_DIN);
  c_sel: cover property ($fell(sel_n));
  c_msg: cover property (!msg_n && !ack_n);
endmodule

// *** tb/scsi_status_sense_handler_test.sv ***
// self-checking bench: both link ends joined, driven from the bus and controller user side
`timescale 1ns/1ps
module scsi_status_sense_handler_test;
  import ssh_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic        done;
  logic        err;
  logic [31:0] sense;
  logic        busy_o;
  logic [47:0] cmd_block_o;
  logic        cmd_valid;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          n_errors;
  int          comparisons;
  int          cycles;
  logic [20:0] sec_exp;
  logic [2:0]  unit;
  logic [31:0] rnd;
  logic        k;

  ssh_link_if link ();
  ssh_target ssh_target_i (.clk_i(clk_i), .rst_i(rst_i), .link(link), .done_i(done),
    .err_i(err), .sense_i(sense), .busy_o(busy_o), .cmd_block_o(cmd_block_o),
    .cmd_valid_o(cmd_valid));
  ssh_initiator ssh_initiator_i (.clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
  ssh_link_assertions ssh_link_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .req_n(link.req_n),
    .ack_n(link.ack_n), .sel_n(link.sel_n), .bsy_n(link.bsy_n), .cd_n(link.cd_n),
    .io_n(link.io_n), .msg_n(link.msg_n), .tgt_data(link.tgt_data), .ini_data(link.ini_data));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // single classic cycle; the request stands until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wb_rd(input logic [7:0] a, input logic [31:0] want, input logic [31:0] msk);
    exp_q.push_back(want & msk);
    msk_q.push_back(msk);
    wb_xfer(1'b0, a, 32'h0000_0000);
  endtask

  // controller finishes a command; it holds the sense block until the next one
  task automatic run_cmd(input logic e, input logic [31:0] s);
    while (busy_o !== 1'b0) @(posedge clk_i);
    done  <= 1'b1;
    err   <= e;
    sense <= s;
    @(posedge clk_i);
    done <= 1'b0;
  endtask

  function automatic logic known(input logic [1:0] t, input logic [3:0] c);
    case (t)
      ET_DRIVE: return c inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
      ET_CTRL:  return c inside {[4'h0:4'h5], 4'h9, 4'ha, 4'hc, 4'hd};
      ET_CMD:   return c <= 4'h5;
      default:  return c <= 4'h2;
    endcase
  endfunction

  // read data is compared against the oldest note at the ack edge
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check({16'h0000, wb_dat_o & msk_q.pop_front()}, {16'h0000, exp_q.pop_front()});
    end
    // only sense requests are ever sent, so the controller never hands a command out
    if (!rst_i && cmd_valid !== 1'b0) begin
      check({47'h0, cmd_valid}, 48'h0);
    end
  end

  // hang guard, well above the 64 sense sequences
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    done = 1'b0;
    err = 1'b0;
    sense = 32'h0000_0000;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    sec_exp = 21'h00_0000;
    rnd = $urandom(32'ha820_1771);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, then an unmapped place
    wb_rd(REG_CTRL, {28'h000_0000, CTRL_RESET}, 32'h0000_000f);
    wb_rd(REG_IRQ_MASK, 32'h0000_0000, 32'h0000_0007);
    wb_rd(REG_SECTOR, 32'h0000_0000, 32'h001f_ffff);
    wb_xfer(1'b1, 8'h40, 32'hffff_ffff);
    wb_rd(8'h40, 32'h0000_0000, 32'hffff_ffff);
    // clean command with the interrupt masked off
    run_cmd(1'b0, $urandom() | 32'h0000_002c); // noisy don't-care status bits
    while (busy_o !== 1'b1) @(posedge clk_i);
    while (busy_o !== 1'b0) @(posedge clk_i);
    check({47'h0, irq_o}, 48'h0); // masked event stays quiet
    wb_rd(REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0007);
    wb_rd(REG_RESULT, 32'h0000_0000, 32'h0000_0102);
    wb_xfer(1'b1, REG_IRQ_MASK, 32'h0000_0007);
    check({47'h0, irq_o}, 48'h1);
    wb_xfer(1'b1, REG_IRQ_STAT, 32'h0000_0007);
    check({47'h0, irq_o}, 48'h0);
    // error flagged with automatic follow-up switched off
    wb_xfer(1'b1, REG_CTRL, 32'h0000_0000);
    run_cmd(1'b1, $urandom());
    while (irq_o !== 1'b1) @(posedge clk_i);
    wb_rd(REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0003);
    wb_rd(REG_RESULT, 32'h0000_0102, 32'h0000_0102);
    wb_xfer(1'b1, REG_IRQ_STAT, 32'h0000_0007);
    // every type and code through the follow-up; only the final done bit interrupts
    wb_xfer(1'b1, REG_IRQ_MASK, 32'h0000_0001);
    for (int i = 0; i < 64; i++) begin
      unit = 3'($urandom());
      rnd = $urandom();
      rnd[29:24] = i[5:0];
      k = known(rnd[29:28], rnd[27:24]);
      if (rnd[31]) sec_exp = rnd[20:0];
      wb_xfer(1'b1, REG_CTRL, {28'h000_0000, unit, 1'b1});
      run_cmd(1'b1, rnd);
      while (irq_o !== 1'b1) @(posedge clk_i);
      wb_rd(REG_IRQ_STAT, {29'h0, ~k, 2'b11}, 32'h0000_0007);
      wb_rd(REG_RESULT, {15'h0, k, rnd[27:24], rnd[29:28], rnd[31], 9'h0}, 32'h0001_fe00);
      wb_rd(REG_SECTOR, {11'h000, sec_exp}, 32'h001f_ffff);
      check(cmd_block_o, {CLASS_BASIC, OP_REQ_SENSE, unit, 5'h00, 32'h0000_0000});
      wb_xfer(1'b1, REG_IRQ_STAT, 32'h0000_0007);
    end
    stop_test();
  end
endmodule
